// file: pkg/pbc_pkg.sv
// constants, types and behaviour notes for the push-button message controller
// Notes on behaviour
// [RQ1] edge press plays current message once, led flashes
// [RQ2] second press stops play, pointer stays put
// [RQ3] play, forward and erase inputs are debounced
// [RQ4] held play loops: play, forward, play next
// [RQ5] release in loop finishes message then stops
// [RQ6] loop without clips: one or two default blinks
// [RQ7] loop with clips: first or second clip plays
// [RQ8] play ignored during record, erase or forward
// [RQ9] forward advances pointer, wraps last to first
// [RQ10] idle forward not at last: single blink
// [RQ11] idle forward at last: wrap, double blink
// [RQ12] forward while playing non-last: advance, resume
// [RQ13] forward while playing last: wrap, resume first
// [RQ14] forward ignored during erase or record
// [RQ15] single erase only on first or last message
// [RQ16] erase first/last: double blink, pointer moves; code steps it back only after last, keeps it at 0 after first
// [RQ17] erase middle: nothing erased, triple blink
// [RQ18] erase during play stops play first
// [RQ19] erase held beyond long press starts global erase
// [RQ20] no clips: seven blinks, early release abandons
// [RQ21] clips: first clip thrice, erase, fourth clip
// [RQ22] erase ignored in record, acts during play
// [RQ23] no new command while indication runs
// [RQ24] four clips in first sixteen rows, four each
// [RQ25] debounce and long press counted in cycles
package pbc_pkg;
	localparam int unsigned CLK_KHZ       = 10_000;
	localparam int unsigned DEBOUNCE_MS   = 20;
	localparam int unsigned LONG_PRESS_MS = 2500;
	localparam int unsigned FIRST_DEFAULT_BLINK_PERIOD_MS  = 200;
	localparam int unsigned SECOND_DEFAULT_BLINK_PERIOD_MS = 200;
	localparam int unsigned THIRD_DEFAULT_BLINK_PERIOD_MS  = 200;
	localparam int unsigned FOURTH_DEFAULT_BLINK_PERIOD_MS = 200;
	localparam int unsigned DEBOUNCE_CYC   = DEBOUNCE_MS * CLK_KHZ;
	localparam int unsigned LONG_PRESS_CYC = LONG_PRESS_MS * CLK_KHZ;
	localparam int unsigned BLINK1_CYC     = FIRST_DEFAULT_BLINK_PERIOD_MS * CLK_KHZ;
	localparam int unsigned BLINK2_CYC     = SECOND_DEFAULT_BLINK_PERIOD_MS * CLK_KHZ;
	localparam int unsigned BLINK3_CYC     = THIRD_DEFAULT_BLINK_PERIOD_MS * CLK_KHZ;
	localparam int unsigned BLINK4_CYC     = FOURTH_DEFAULT_BLINK_PERIOD_MS * CLK_KHZ;
	localparam int          PTR_W     = 8;
	localparam int          NBTN      = 3;
	localparam int          BTN_PLAY  = 0;
	localparam int          BTN_FWD   = 1;
	localparam int          BTN_ERASE = 2;
	localparam int          ROW_SHIFT = 2;
	localparam logic [2:0]  ONE_BLINK   = 3'h1;
	localparam logic [2:0]  TWO_BLINK   = 3'h2;
	localparam logic [2:0]  THREE_BLINK = 3'h3;
	localparam logic [2:0]  FOUR_BLINK  = 3'h4;
	localparam logic [1:0]  CLIP_FIRST  = 2'h0;
	localparam logic [1:0]  CLIP_SECOND = 2'h1;
	localparam logic [1:0]  CLIP_THIRD  = 2'h2;
	localparam logic [1:0]  CLIP_FOURTH = 2'h3;
	localparam logic [1:0]  ONE_REP     = 2'h1;
	localparam logic [1:0]  WARN_REPS   = 2'h3;

	typedef enum logic [1:0] {S_IDLE, S_PLAY, S_IND, S_GER} pbc_state_e;
	typedef enum logic [1:0] {N_IDLE, N_PLAY, N_GER} pbc_next_e;

	typedef struct packed {
		logic play_end;
		logic clip_end;
		logic gerase_done;
	} pbc_eng_s;

	typedef struct packed {
		pbc_state_e             st;
		pbc_next_e              nxt;
		logic [NBTN-1:0]        sync1;
		logic [NBTN-1:0]        sync2;
		logic [NBTN-1:0]        db;
		logic [NBTN-1:0]        dbp;
		logic [NBTN-1:0][31:0]  dcnt;
		logic [31:0]            hold;
		logic [31:0]            tmr;
		logic [31:0]            per;
		logic [2:0]             blinks;
		logic [1:0]             reps;
		logic [1:0]             clip;
		logic                   use_clip;
		logic                   armed;
		logic [PTR_W-1:0]       ptr;
		logic [PTR_W-1:0]       erase_idx;
		logic [3:0]             clip_row;
		logic                   led;
		logic                   play_start;
		logic                   play_stop;
		logic                   clip_start;
		logic                   erase_msg;
		logic                   gerase_start;
	} pbc_st_s;

	localparam pbc_st_s PBC_RST = '{st: S_IDLE, nxt: N_IDLE, sync1: 3'h7, sync2: 3'h7,
		db: 3'h7, dbp: 3'h7, default: '0};
endpackage

// file: core/pbc_core.sv
// push-button play, forward and erase controller
module pbc_core import pbc_pkg::*; #(
	parameter int unsigned DB_CYC   = DEBOUNCE_CYC,
	parameter int unsigned LONG_CYC = LONG_PRESS_CYC,
	parameter int unsigned P1_CYC   = BLINK1_CYC,
	parameter int unsigned P2_CYC   = BLINK2_CYC,
	parameter int unsigned P3_CYC   = BLINK3_CYC,
	parameter int unsigned P4_CYC   = BLINK4_CYC
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// buttons, active low pins
	input  wire logic             play_button_n,
	input  wire logic             forward_button_n,
	input  wire logic             erase_button_n,
	// message memory status
	input  wire logic             record_busy,
	input  wire logic [PTR_W-1:0] msg_count,
	input  wire logic [3:0]       clip_programmed,
	// playback engine answers
	input  wire pbc_eng_s         eng,
	// indicator
	output logic                  led,
	// playback engine requests
	output logic                  play_start,
	output logic                  play_stop,
	output logic [PTR_W-1:0]      play_msg,
	output logic                  clip_start,
	output logic [3:0]            clip_row,
	// memory requests
	output logic                  erase_msg,
	output logic [PTR_W-1:0]      erase_idx,
	output logic                  gerase_start
);

	if (DB_CYC < 2 || LONG_CYC < 2 || P1_CYC < 2 || P2_CYC < 2 || P3_CYC < 2 ||
		P4_CYC < 2) begin : g_bad_count
		$error("pbc_core: every cycle count must be at least two");
	end

	localparam logic [31:0] DB_LAST   = 32'(DB_CYC - 1);
	localparam logic [31:0] LONG_HOLD = 32'(LONG_CYC);
	localparam logic [31:0] P1        = 32'(P1_CYC);
	localparam logic [31:0] P2        = 32'(P2_CYC);
	localparam logic [31:0] P3        = 32'(P3_CYC);
	localparam logic [31:0] P4        = 32'(P4_CYC);

	pbc_st_s          r;
	pbc_st_s          n;
	logic [NBTN-1:0]  pin;
	logic [NBTN-1:0]  fall;
	logic             at_first;
	logic             at_last;
	logic             long_hit;

	assign pin      = {erase_button_n, forward_button_n, play_button_n};
	assign fall     = r.dbp & ~r.db;
	assign at_first = (msg_count != '0) && (r.ptr == '0);
	assign at_last  = (msg_count != '0) && (r.ptr == msg_count - PTR_W'(1));
	assign long_hit = (r.hold == LONG_HOLD);

	// open an indication: blinks at a default period, or a clip with blinking beside it
	function automatic pbc_st_s ind(pbc_st_s s, logic [2:0] nb, logic [1:0] ci,
		logic [1:0] reps, pbc_next_e nx, logic [31:0] per, logic prog);
		s.st         = S_IND;
		s.blinks     = nb;
		s.clip       = ci;
		s.reps       = reps;
		s.nxt        = nx;
		s.per        = per;
		s.tmr        = 32'h0;
		s.led        = 1'b1;
		s.use_clip   = prog;
		s.clip_start = prog;
		s.clip_row   = 4'(ci) << ROW_SHIFT; // see [RQ24]
		return s;
	endfunction

	function automatic pbc_st_s fwd_op(pbc_st_s s, pbc_next_e nx, logic lst,
		logic [3:0] prog);
		if (lst) begin
			s.ptr = '0; // see [RQ9]
			s = ind(s, TWO_BLINK, CLIP_SECOND, ONE_REP, nx, P2, prog[1]); // see [RQ11] [RQ13]
		end else begin
			s.ptr = s.ptr + PTR_W'(1);
			s = ind(s, ONE_BLINK, CLIP_FIRST, ONE_REP, nx, P1, prog[0]); // see [RQ10] [RQ12]
		end
		return s;
	endfunction

	function automatic pbc_st_s erase_op(pbc_st_s s, logic fst, logic lst,
		logic [3:0] prog);
		// middle messages are never erased one at a time
		if (fst || lst) begin // see [RQ15]
			s.erase_msg = 1'b1;
			s.erase_idx = s.ptr;
			if (!fst) begin
				s.ptr = s.ptr - PTR_W'(1);
			end
			s = ind(s, TWO_BLINK, CLIP_SECOND, ONE_REP, N_IDLE, P2, prog[1]); // see [RQ16]
		end else begin
			s = ind(s, THREE_BLINK, CLIP_THIRD, ONE_REP, N_IDLE, P3, prog[2]); // see [RQ17]
		end
		s.armed = 1'b1;
		return s;
	endfunction

	always_comb begin
		logic fin;
		fin = 1'b0;
		n = r;
		n.play_start   = 1'b0;
		n.play_stop    = 1'b0;
		n.clip_start   = 1'b0;
		n.erase_msg    = 1'b0;
		n.gerase_start = 1'b0;
		// a press counts only once the pin has held its level for the full count
		for (int i = 0; i < NBTN; i++) begin
			n.sync1[i] = pin[i];
			n.sync2[i] = r.sync1[i];
			n.dbp[i]   = r.db[i];
			if (r.sync2[i] == r.db[i]) begin
				n.dcnt[i] = 32'h0;
			end else if (r.dcnt[i] == DB_LAST) begin
				n.db[i]   = r.sync2[i]; // see [RQ3] [RQ25]
				n.dcnt[i] = 32'h0;
			end else begin
				n.dcnt[i] = r.dcnt[i] + 32'h1;
			end
		end
		if (r.db[BTN_ERASE]) begin
			n.hold = 32'h0;
		end else if (!long_hit) begin
			n.hold = r.hold + 32'h1; // see [RQ25]
		end

		case (r.st)
			S_IDLE: begin
				n.led = 1'b0;
				if (r.armed && r.db[BTN_ERASE]) begin
					n.armed = 1'b0;
				end
				if (record_busy) begin
					n.st = S_IDLE; // see [RQ8] [RQ14] [RQ22]
				end else if (r.armed && long_hit) begin
					// warning phase: three blinks or three first clips
					n.armed = 1'b0;
					n = ind(n, THREE_BLINK, CLIP_FIRST, WARN_REPS, N_GER, P1,
						clip_programmed[0]); // see [RQ19] [RQ20] [RQ21]
				end else if (fall[BTN_ERASE]) begin
					n = erase_op(n, at_first, at_last, clip_programmed); // see [RQ16] [RQ17]
				end else if (fall[BTN_FWD] && msg_count != '0) begin
					n = fwd_op(n, N_IDLE, at_last, clip_programmed); // see [RQ9] [RQ10] [RQ11]
				end else if (fall[BTN_PLAY] && msg_count != '0) begin
					n.st         = S_PLAY; // see [RQ1]
					n.play_start = 1'b1;
					n.led        = 1'b1;
					n.tmr        = 32'h0;
				end
			end
			S_PLAY: begin
				if (r.tmr == P1 - 32'h1) begin
					n.tmr = 32'h0;
					n.led = ~r.led; // see [RQ1] [RQ4]
				end else begin
					n.tmr = r.tmr + 32'h1;
				end
				if (fall[BTN_ERASE]) begin
					n.play_stop = 1'b1; // see [RQ18] [RQ22]
					n = erase_op(n, at_first, at_last, clip_programmed);
				end else if (fall[BTN_FWD]) begin
					n.play_stop = 1'b1; // see [RQ12] [RQ13]
					n = fwd_op(n, N_PLAY, at_last, clip_programmed);
				end else if (fall[BTN_PLAY]) begin
					n.play_stop = 1'b1; // see [RQ2]
					n.st        = S_IDLE;
					n.led       = 1'b0;
				end else if (eng.play_end) begin
					if (!r.db[BTN_PLAY]) begin
						n = fwd_op(n, N_PLAY, at_last, clip_programmed); // see [RQ4] [RQ6] [RQ7]
					end else begin
						n.st  = S_IDLE; // see [RQ1] [RQ5]
						n.led = 1'b0;
					end
				end
			end
			S_IND: begin
				// buttons are not looked at here, only the erase hold of a warning
				if (r.nxt == N_GER && r.db[BTN_ERASE]) begin
					n.st  = S_IDLE; // see [RQ20] [RQ21]
					n.led = 1'b0;
				end else begin
					if (r.tmr == r.per - 32'h1) begin
						n.tmr = 32'h0;
						n.led = ~r.led;
						if (!r.use_clip && !r.led) begin
							if (r.blinks == ONE_BLINK) begin
								fin = 1'b1;
							end else begin
								n.blinks = r.blinks - 3'h1; // see [RQ6] [RQ20]
							end
						end
					end else begin
						n.tmr = r.tmr + 32'h1;
					end
					// a clip bounds the blinking; the warning replays its clip
					if (r.use_clip && eng.clip_end) begin
						if (r.reps == ONE_REP) begin
							fin = 1'b1; // see [RQ7]
						end else begin
							n.reps       = r.reps - 2'h1; // see [RQ21]
							n.clip_start = 1'b1;
						end
					end
					if (fin) begin
						n.led = 1'b0;
						case (r.nxt)
							N_PLAY: begin
								n.st         = S_PLAY; // see [RQ4] [RQ12] [RQ13]
								n.play_start = 1'b1;
								n.led        = 1'b1;
								n.tmr        = 32'h0;
							end
							N_GER: begin
								n.st           = S_GER; // see [RQ19]
								n.gerase_start = 1'b1;
							end
							default: begin
								n.st = S_IDLE; // see [RQ23]
							end
						endcase
					end
				end
			end
			S_GER: begin
				n.led = 1'b0;
				if (eng.gerase_done) begin
					n = ind(n, FOUR_BLINK, CLIP_FOURTH, ONE_REP, N_IDLE, P4,
						clip_programmed[3]); // see [RQ20] [RQ21]
				end
			end
			default: begin
				n.st = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r <= PBC_RST;
		end else begin
			r <= n;
		end
	end

	assign led          = r.led;
	assign play_start   = r.play_start;
	assign play_stop    = r.play_stop;
	assign play_msg     = r.ptr;
	assign clip_start   = r.clip_start;
	assign clip_row     = r.clip_row;
	assign erase_msg    = r.erase_msg;
	assign erase_idx    = r.erase_idx;
	assign gerase_start = r.gerase_start;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	logic idle_go;
	assign idle_go = r.st == S_IDLE && !record_busy && !r.armed && !fall[BTN_ERASE];

	a_play_edge_start: assert property ( // see [RQ1]
		idle_go && !fall[BTN_FWD] && fall[BTN_PLAY] && msg_count != '0
		|=> r.st == S_PLAY && r.play_start && r.led)
		else $error("play press in idle did not start playback");

	a_play_second_stop: assert property ( // see [RQ2]
		r.st == S_PLAY && fall[BTN_PLAY] && !fall[BTN_FWD] && !fall[BTN_ERASE]
		|=> r.play_stop && r.st == S_IDLE && $stable(r.ptr))
		else $error("second play press did not stop playback in place");

	a_busy_ignores: assert property ( // see [RQ8]
		r.st == S_IDLE && record_busy
		|=> !r.play_start && !r.erase_msg && r.st == S_IDLE && $stable(r.ptr))
		else $error("button acted while record was busy");

	a_fwd_wraps: assert property ( // see [RQ9]
		idle_go && fall[BTN_FWD] && at_last
		|=> r.ptr == '0 && r.st == S_IND && r.blinks == TWO_BLINK)
		else $error("forward from last message did not wrap");

	a_loop_continue: assert property ( // see [RQ4]
		r.st == S_PLAY && eng.play_end && !r.db[BTN_PLAY] && fall == '0
		|=> r.st == S_IND && r.nxt == N_PLAY)
		else $error("held play did not advance to next message");

	a_loop_release: assert property ( // see [RQ5]
		r.st == S_PLAY && eng.play_end && r.db[BTN_PLAY] && fall == '0
		|=> r.st == S_IDLE && $stable(r.ptr) && !r.led)
		else $error("released loop did not halt on its message");

	a_erase_middle: assert property ( // see [RQ17]
		r.st == S_IDLE && !record_busy && !r.armed && fall[BTN_ERASE] && !at_first &&
		!at_last
		|=> !r.erase_msg && r.st == S_IND && r.blinks == THREE_BLINK && $stable(r.ptr))
		else $error("middle message erase not rejected");

	a_ind_quiet: assert property ( // see [RQ23]
		r.st == S_IND && r.nxt == N_IDLE
		|=> !r.play_start && !r.erase_msg && !r.play_stop)
		else $error("command accepted during indication");

	a_warn_abandon: assert property ( // see [RQ20]
		r.st == S_IND && r.nxt == N_GER && r.db[BTN_ERASE]
		|=> r.st == S_IDLE && !r.gerase_start ##1 !r.gerase_start)
		else $error("released erase did not abandon global erase");

	a_db_settled: assert property ( // see [RQ3]
		r.db[BTN_PLAY] != $past(r.db[BTN_PLAY]) |-> $past(r.dcnt[BTN_PLAY]) == DB_LAST)
		else $error("play level changed before debounce count");

	a_gerase_held: assert property ( // see [RQ19]
		r.gerase_start |-> $past(r.st) == S_IND && !$past(r.db[BTN_ERASE]) && r.st == S_GER)
		else $error("global erase started without held erase");

	a_erase_first: assert property ( // see [RQ16]
		r.st == S_IDLE && !record_busy && !r.armed && fall[BTN_ERASE] && at_first
		|=> r.erase_msg && r.erase_idx == '0 && r.ptr == '0 && r.blinks == TWO_BLINK)
		else $error("erase of first message not carried out");

	a_fwd_resume: assert property ( // see [RQ12]
		r.st == S_PLAY && fall[BTN_FWD] && !fall[BTN_ERASE] && !at_last
		|=> r.play_stop && r.st == S_IND && r.nxt == N_PLAY &&
		r.ptr == $past(r.ptr) + PTR_W'(1))
		else $error("forward in play did not advance and resume");

	// each warning clip but the last must be started again
	a_warn_replay: assert property ( // see [RQ21]
		r.st == S_IND && r.nxt == N_GER && !r.db[BTN_ERASE] && r.use_clip &&
		eng.clip_end && r.reps != ONE_REP
		|=> r.clip_start && r.st == S_IND)
		else $error("warning clip was not replayed");

	a_clip_rows: assert property ( // see [RQ24]
		r.clip_start |-> r.clip_row == {r.clip, 2'h0})
		else $error("clip started from a wrong row");

endmodule // pbc_core

// file: bench/pbc_eng_model.sv
// playback engine and memory timing model facing the controller
module pbc_eng_model import pbc_pkg::*; (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        resetn,
	// requests from the controller
	input  wire logic        play_start,
	input  wire logic        play_stop,
	input  wire logic        clip_start,
	input  wire logic        gerase_start,
	// message length in cycles, set by the bench
	input  wire logic [15:0] play_len,
	// answers
	output pbc_eng_s         eng
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] pt;
	logic [15:0] ct;
	logic [15:0] gt;
	// a halted message never reports its end, as the real engine would not
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pt <= '0;
			ct <= '0;
			gt <= '0;
			eng <= '0;
		end else begin
			pt <= play_stop ? 16'h0 : play_start ? play_len : (pt != 0) ? pt - 16'h1 : pt;
			ct <= clip_start ? 16'h6 : (ct != 0) ? ct - 16'h1 : ct;
			gt <= gerase_start ? 16'hA : (gt != 0) ? gt - 16'h1 : gt;
			eng.play_end <= pt == 16'h1 && !play_stop;
			eng.clip_end <= ct == 16'h1;
			eng.gerase_done <= gt == 16'h1;
		end
	end
endmodule // pbc_eng_model

// file: bench/test_pushbutton_play_forward_erase_control.sv
// self-checking bench for the push-button controller
module test_pushbutton_play_forward_erase_control import pbc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0;
	logic        resetn = 0;
	logic        record_busy = 0;
	logic [2:0]  btn_n = 3'h7;
	logic [7:0]  msg_count = 8'h3;
	logic [3:0]  clip_programmed = 4'h0;
	logic [15:0] play_len = 16'h1E;
	pbc_eng_s    eng;
	logic        led, play_start, play_stop, clip_start, erase_msg, gerase_start, led_d;
	logic [7:0]  play_msg, erase_idx;
	logic [3:0]  clip_row;
	logic [7:0]  n_start, n_stop, n_clip, n_erase, n_ger, n_led;
	int          err_count = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	always #50 clk = ~clk;
	// third period stays at its default: the middle erase runs with its clip
	pbc_core #(.DB_CYC(4), .LONG_CYC(200), .P1_CYC(8), .P2_CYC(8), .P4_CYC(8))
	pbc_core_i (.clk(clk), .resetn(resetn), .play_button_n(btn_n[BTN_PLAY]),
		.forward_button_n(btn_n[BTN_FWD]), .erase_button_n(btn_n[BTN_ERASE]),
		.record_busy(record_busy), .msg_count(msg_count), .clip_programmed(clip_programmed),
		.eng(eng), .led(led), .play_start(play_start), .play_stop(play_stop),
		.play_msg(play_msg), .clip_start(clip_start), .clip_row(clip_row),
		.erase_msg(erase_msg), .erase_idx(erase_idx), .gerase_start(gerase_start));
	pbc_eng_model pbc_eng_model_i (.clk(clk), .resetn(resetn), .play_start(play_start),
		.play_stop(play_stop), .clip_start(clip_start), .gerase_start(gerase_start),
		.play_len(play_len), .eng(eng));
	// event counters, cleared by each test
	always @(posedge clk) begin
		led_d <= led;
		n_start <= n_start + 8'(play_start);
		n_stop <= n_stop + 8'(play_stop);
		n_clip <= n_clip + 8'(clip_start);
		n_erase <= n_erase + 8'(erase_msg);
		n_ger <= n_ger + 8'(gerase_start);
		n_led <= n_led + 8'(led & ~led_d);
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_count++;
			final_report;
		end
	end
	task final_report;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(string what, logic [7:0] exp, logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task clr;
		@(negedge clk);
		{n_start, n_stop, n_clip, n_erase, n_ger, n_led} = '0;
	endtask
	task press(int b, int hold);
		@(negedge clk) btn_n[b] = 1'b0;
		repeat (hold) @(negedge clk);
		btn_n[b] = 1'b1;
	endtask
	// quiet means led dark long enough to outlast any blink gap
	task settle;
		int q;
		q = 0;
		for (int i = 0; i < 3000 && q < 40; i++) begin
			@(negedge clk);
			q = led ? 0 : q + 1;
		end
	endtask
	task t_edge;
		clr;
		press(BTN_PLAY, 2);
		settle;
		chk("glitch", 0, n_start);
		press(BTN_PLAY, 10);
		settle;
		chk("play_start", 1, n_start);
		chk("led_blink", 1, 8'(n_led != 0));
		chk("play_msg", 0, play_msg);
		$display("test edge play done");
	endtask
	task t_stop;
		play_len = 16'h12C;
		clr;
		press(BTN_PLAY, 10);
		repeat (20) @(negedge clk);
		press(BTN_PLAY, 10);
		settle;
		chk("play_stop", 1, n_stop);
		chk("play_msg", 0, play_msg);
		play_len = 16'h1E;
		$display("test play stop done");
	endtask
	task t_ind;
		clr;
		press(BTN_FWD, 10);
		press(BTN_PLAY, 6);
		settle;
		chk("play_start", 0, n_start);
		chk("play_msg", 1, play_msg);
		$display("test busy indication done");
	endtask
	task t_busy;
		record_busy = 1'b1;
		clr;
		press(BTN_PLAY, 10);
		press(BTN_FWD, 10);
		press(BTN_ERASE, 10);
		settle;
		record_busy = 1'b0;
		chk("play_start", 0, n_start);
		chk("erase_msg", 0, n_erase);
		chk("play_msg", 1, play_msg);
		$display("test record busy done");
	endtask
	// an empty memory leaves play and forward without effect
	task t_empty;
		msg_count = 8'h0;
		clr;
		press(BTN_PLAY, 10);
		press(BTN_FWD, 10);
		settle;
		chk("play_start", 0, n_start);
		chk("led_blinks", 0, n_led);
		msg_count = 8'h3;
		$display("test empty memory done");
	endtask
	task fwd_chk(logic [7:0] p, logic [7:0] l, logic [7:0] c);
		clr;
		press(BTN_FWD, 10);
		settle;
		chk("play_msg", p, play_msg);
		chk("clip_start", c, n_clip);
		if (c == 0) chk("led_blinks", l, n_led);
		else chk("clip_row", l, 8'(clip_row));
	endtask
	task t_fwd;
		fwd_chk(2, 1, 0);
		fwd_chk(0, 2, 0);
		clip_programmed = 4'h3;
		fwd_chk(1, 0, 1);
		fwd_chk(2, 0, 1);
		fwd_chk(0, 4, 1);
		clip_programmed = 4'h0;
		$display("test forward done");
	endtask
	task t_fwd_play;
		clr;
		press(BTN_PLAY, 10);
		press(BTN_FWD, 10);
		settle;
		chk("play_stop", 1, n_stop);
		chk("play_start", 2, n_start);
		chk("play_msg", 1, play_msg);
		press(BTN_FWD, 10);
		settle;
		clr;
		press(BTN_PLAY, 10);
		press(BTN_FWD, 10);
		settle;
		chk("play_start", 2, n_start);
		chk("play_msg", 0, play_msg);
		$display("test forward in play done");
	endtask
	task t_erase;
		clr;
		press(BTN_ERASE, 10);
		settle;
		chk("erase_msg", 1, n_erase);
		chk("erase_idx", 0, erase_idx);
		chk("led_blinks", 2, n_led);
		press(BTN_FWD, 10);
		settle;
		clip_programmed = 4'h4;
		clr;
		press(BTN_ERASE, 10);
		settle;
		chk("erase_msg", 0, n_erase);
		chk("clip_start", 1, n_clip);
		chk("clip_row", 8, 8'(clip_row));
		chk("play_msg", 1, play_msg);
		clip_programmed = 4'h0;
		press(BTN_FWD, 10);
		settle;
		clr;
		press(BTN_PLAY, 10);
		press(BTN_ERASE, 10);
		settle;
		chk("play_stop", 1, n_stop);
		chk("erase_idx", 2, erase_idx);
		chk("play_msg", 1, play_msg);
		$display("test erase done");
	endtask
	task t_loop;
		clr;
		@(negedge clk) btn_n[BTN_PLAY] = 1'b0;
		for (int i = 0; i < 3000 && n_start < 3; i++) @(negedge clk);
		btn_n[BTN_PLAY] = 1'b1;
		settle;
		chk("play_start", 3, n_start);
		chk("play_stop", 0, n_stop);
		chk("play_msg", 0, play_msg);
		$display("test loop play done");
	endtask
	task t_gerase;
		clr;
		press(BTN_ERASE, 210);
		settle;
		chk("gerase_start", 0, n_ger);
		clr;
		press(BTN_ERASE, 400);
		settle;
		chk("gerase_start", 1, n_ger);
		chk("led_blinks", 9, n_led);
		clip_programmed = 4'h1;
		clr;
		press(BTN_ERASE, 400);
		settle;
		chk("clip_start", 3, n_clip);
		chk("gerase_start", 1, n_ger);
		clip_programmed = 4'h0;
		$display("test global erase done");
	endtask
	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk) resetn = 1'b1;
		repeat (5) @(negedge clk);
		t_edge;
		t_stop;
		t_ind;
		t_busy;
		t_fwd;
		t_fwd_play;
		t_erase;
		t_empty;
		t_loop;
		t_gerase;
		final_report;
	end
endmodule // test_pushbutton_play_forward_erase_control
